// [common/rcs_pkg.sv]
// Constants and types shared by the radio configuration and status register block
package rcs_pkg;
	// Register offsets
	localparam logic [4:0] OFS_CHANNEL  = 5'h05;
	localparam logic [4:0] OFS_SETUP    = 5'h06;
	localparam logic [4:0] OFS_STATUS   = 5'h07;
	localparam logic [4:0] OFS_OBSERVE  = 5'h08;
	localparam logic [4:0] OFS_POWERDET = 5'h09;
	localparam logic [4:0] OFS_PIPE0    = 5'h0A;
	localparam logic [4:0] OFS_PIPE1    = 5'h0B;
	localparam logic [4:0] OFS_PIPE2    = 5'h0C;
	localparam logic [4:0] OFS_PIPE3    = 5'h0D;

	// Field positions in the setup register, and the channel field width
	localparam int SETUP_CARRIER = 7;
	localparam int SETUP_SLOW    = 5;
	localparam int SETUP_LOCK    = 4;
	localparam int SETUP_FAST    = 3;
	localparam int SETUP_PWR_LSB = 1;
	localparam int CHANNEL_BITS  = 7;

	// Field positions in the status and observe registers
	localparam int STS_RX       = 6;
	localparam int STS_TX       = 5;
	localparam int STS_RETRY    = 4;
	localparam int STS_PIPE_LSB = 1;
	localparam int STS_FULL     = 0;
	localparam int OBS_LOST_LSB = 4;

	// Reset values, write masks and the lost counter limit
	localparam logic [7:0]  CHANNEL_RST   = 8'h02;
	localparam logic [7:0]  SETUP_RST     = 8'h0E;
	localparam logic [7:0]  SETUP_WMASK   = 8'hBE;
	localparam logic [2:0]  PIPE_NO_EMPTY = 3'h7;
	localparam logic [39:0] PIPE0_RST     = 40'hE7_E7E7_E7E7;
	localparam logic [39:0] PIPE1_RST     = 40'hC2_C2C2_C2C2;
	localparam logic [7:0]  PIPE2_RST     = 8'hC3;
	localparam logic [7:0]  PIPE3_RST     = 8'hC4;
	localparam logic [3:0]  LOST_MAX      = 4'hF;

	// Serial command byte: top three bits select read or write, low five the offset
	localparam logic [2:0]  CMD_READ  = 3'h0;
	localparam logic [2:0]  CMD_WRITE = 3'h1;
	localparam logic [2:0]  ADDR_BYTES_MAX = 3'h5;

	// Air data rate as decoded from the setup register
	typedef enum logic [1:0] {
		RCS_RATE_1M,
		RCS_RATE_2M,
		RCS_RATE_250K,
		RCS_RATE_RSVD
	} rcs_rate_e;

	// Serial port phases
	typedef enum logic [1:0] {
		RCS_SPI_IDLE,
		RCS_SPI_CMD,
		RCS_SPI_DATA
	} rcs_spi_e;
endpackage : rcs_pkg

// [design/rcs_radio_regs.sv]
// Radio channel, setup, status, counters and pipe address registers behind a serial command port
`timescale 1ns/1ns
module rcs_radio_regs (
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_reset_n,
	// Serial command port, mode 0
	input  wire logic              i_spi_sck,
	input  wire logic              i_spi_cs_n,
	input  wire logic              i_spi_mosi,
	output logic                   o_spi_miso,
	output logic                   o_spi_miso_en,
	// Settings held elsewhere in the device
	input  wire logic [1:0]        i_addr_width_cfg,
	input  wire logic [3:0]        i_retry_limit,
	input  wire logic              i_auto_acknowledge,
	input  wire logic [2:0]        i_irq_mask,
	// Packet engine events and state
	input  wire logic              i_rx_packet_stored,
	input  wire logic [2:0]        i_rx_head_pipe,
	input  wire logic              i_tx_fifo_full,
	input  wire logic              i_tx_packet_start,
	input  wire logic              i_tx_packet_done,
	input  wire logic              i_ack_received,
	input  wire logic              i_ack_missed,
	input  wire logic              i_power_detect,
	// Radio controls
	output logic [6:0]             o_channel_number,
	output logic                   o_carrier_test_enable,
	output rcs_pkg::rcs_rate_e     o_data_rate,
	output logic                   o_force_lock,
	output logic [1:0]             o_tx_power_level,
	output logic                   o_retransmit_request,
	output logic                   o_link_blocked,
	output logic                   o_radio_irq_n,
	// Receive addresses, bytes beyond the configured width read zero
	output logic [39:0]            o_pipe0_match_address,
	output logic [39:0]            o_pipe1_match_address,
	output logic [39:0]            o_pipe2_match_address,
	output logic [39:0]            o_pipe3_match_address
);

	// Register state
	logic [7:0]  channel_q;
	logic [7:0]  setup_q;
	logic        rx_ready_flag_q;
	logic        tx_sent_flag_q;
	logic        retry_exhausted_flag_q;
	logic [2:0]  head_pipe_q;
	logic        tx_full_q;
	logic [3:0]  lost_packet_count_q;
	logic [3:0]  retry_count_q;
	logic        power_detect_q;
	logic [39:0] pipe0_q;
	logic [39:0] pipe1_q;
	logic [7:0]  pipe2_q;
	logic [7:0]  pipe3_q;

	// Serial engine state
	rcs_pkg::rcs_spi_e spi_state_q;
	logic        sck_q;
	logic        cs_n_q;
	logic [2:0]  bit_cnt_q;
	logic [2:0]  byte_cnt_q;
	logic [7:0]  rx_shift_q;
	logic [7:0]  tx_shift_q;
	logic [7:0]  cmd_q;
	logic [39:0] wbuf_q;

	// Decoded strobes
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        byte_done;
	logic [7:0]  in_byte;
	logic        commit;
	logic [7:0]  wdata;
	logic [7:0]  status_byte;
	logic        wr_channel;
	logic        wr_status;
	logic        tx_sent_set;
	logic        retry_left;
	logic [39:0] width_mask;
	logic [39:0] read_val;

	// Merge the received low bytes of a multi-byte write over the old value
	function automatic logic [39:0] merge_bytes(input logic [39:0] old_v, input logic [39:0] new_v,
			input logic [2:0] n);
		logic [39:0] m;
		m = '0;
		for (int k = 0; k < 5; k++) begin
			if (3'(k) < n) begin
				m[8*k +: 8] = 8'hFF;
			end
		end
		return (new_v & m) | (old_v & ~m);
	endfunction : merge_bytes

	// Full read value of a register; only offsets of this block answer
	function automatic logic [39:0] read_word(input logic [4:0] ofs, input logic [7:0] sts);
		logic [39:0] v;
		v = '0;
		unique case (ofs)
			rcs_pkg::OFS_CHANNEL:  v[7:0] = channel_q;
			rcs_pkg::OFS_SETUP:    v[7:0] = setup_q;
			rcs_pkg::OFS_STATUS:   v[7:0] = sts;
			rcs_pkg::OFS_OBSERVE:  v[7:0] = {lost_packet_count_q, retry_count_q};
			rcs_pkg::OFS_POWERDET: v[7:0] = {7'h00, power_detect_q};
			rcs_pkg::OFS_PIPE0:    v = pipe0_q;
			rcs_pkg::OFS_PIPE1:    v = pipe1_q;
			rcs_pkg::OFS_PIPE2:    v[7:0] = pipe2_q;
			rcs_pkg::OFS_PIPE3:    v[7:0] = pipe3_q;
			default:               v = '0;
		endcase
		return v;
	endfunction : read_word

	// Edge detection on the port pins, taken as synchronous
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sck_q  <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sck_q  <= i_spi_sck;
			cs_n_q <= i_spi_cs_n;
		end
	end

	assign sck_rise  = !i_spi_cs_n && i_spi_sck && !sck_q;
	assign sck_fall  = !i_spi_cs_n && !i_spi_sck && sck_q;
	assign cs_fall   = !i_spi_cs_n && cs_n_q;
	assign cs_rise   = i_spi_cs_n && !cs_n_q;
	assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
	assign in_byte   = {rx_shift_q[6:0], i_spi_mosi};

	// Status byte; the reserved top bit reads zero
	assign status_byte = {1'b0, rx_ready_flag_q, tx_sent_flag_q, retry_exhausted_flag_q,
		head_pipe_q, tx_full_q};

	// Command phase tracking and byte counting
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			spi_state_q <= rcs_pkg::RCS_SPI_IDLE;
			bit_cnt_q   <= 3'h0;
			byte_cnt_q  <= 3'h0;
			rx_shift_q  <= 8'h00;
			cmd_q       <= 8'h00;
		end else if (i_spi_cs_n) begin
			spi_state_q <= rcs_pkg::RCS_SPI_IDLE;
		end else if (cs_fall) begin
			spi_state_q <= rcs_pkg::RCS_SPI_CMD;
			bit_cnt_q   <= 3'h0;
			byte_cnt_q  <= 3'h0;
		end else if (sck_rise) begin
			rx_shift_q <= in_byte;
			bit_cnt_q  <= bit_cnt_q + 3'h1;
			if (byte_done) begin
				// Count saturates so that overlong writes cannot wrap
				if (byte_cnt_q != 3'h7) begin
					byte_cnt_q <= byte_cnt_q + 3'h1;
				end
				unique case (spi_state_q)
					rcs_pkg::RCS_SPI_CMD: begin
						cmd_q       <= in_byte;
						spi_state_q <= rcs_pkg::RCS_SPI_DATA;
					end
					rcs_pkg::RCS_SPI_DATA: spi_state_q <= rcs_pkg::RCS_SPI_DATA;
					default:               spi_state_q <= rcs_pkg::RCS_SPI_IDLE;
				endcase
			end
		end
	end

	// Data bytes collect low byte first; extra bytes past five are dropped
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wbuf_q <= '0;
		end else if (byte_done && spi_state_q == rcs_pkg::RCS_SPI_DATA
				&& byte_cnt_q <= rcs_pkg::ADDR_BYTES_MAX) begin
			wbuf_q[8*(byte_cnt_q - 3'h1) +: 8] <= in_byte;
		end
	end

	// Whole read value of the addressed register, sliced per byte below
	always_comb begin
		read_val = read_word(cmd_q[4:0], status_byte);
	end

	// Output shifter: status during the command byte, then read data
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_shift_q <= 8'h00;
		end else if (cs_fall) begin
			tx_shift_q <= status_byte;
		end else if (sck_fall) begin
			if (bit_cnt_q == 3'h0 && byte_cnt_q != 3'h0 && byte_cnt_q <= rcs_pkg::ADDR_BYTES_MAX) begin
				tx_shift_q <= read_val[8*(byte_cnt_q - 3'h1) +: 8];
			end else begin
				tx_shift_q <= {tx_shift_q[6:0], 1'b0};
			end
		end
	end

	assign o_spi_miso    = tx_shift_q[7];
	assign o_spi_miso_en = !i_spi_cs_n;

	// Writes land only when chip select rises with at least one data byte
	assign commit     = cs_rise && spi_state_q == rcs_pkg::RCS_SPI_DATA
		&& cmd_q[7:5] == rcs_pkg::CMD_WRITE && byte_cnt_q >= 3'h2;
	assign wdata      = wbuf_q[7:0];
	assign wr_channel = commit && cmd_q[4:0] == rcs_pkg::OFS_CHANNEL;
	assign wr_status  = commit && cmd_q[4:0] == rcs_pkg::OFS_STATUS;

	// Channel and setup registers
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			channel_q <= rcs_pkg::CHANNEL_RST;
			setup_q   <= rcs_pkg::SETUP_RST;
		end else if (commit) begin
			if (cmd_q[4:0] == rcs_pkg::OFS_CHANNEL) begin
				channel_q <= {1'b0, wdata[rcs_pkg::CHANNEL_BITS-1:0]};
			end
			if (cmd_q[4:0] == rcs_pkg::OFS_SETUP) begin
				setup_q <= wdata & rcs_pkg::SETUP_WMASK;
			end
		end
	end

	// Pipe address registers; bytes not sent keep their old value
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pipe0_q <= rcs_pkg::PIPE0_RST;
			pipe1_q <= rcs_pkg::PIPE1_RST;
			pipe2_q <= rcs_pkg::PIPE2_RST;
			pipe3_q <= rcs_pkg::PIPE3_RST;
		end else if (commit) begin
			unique case (cmd_q[4:0])
				rcs_pkg::OFS_PIPE0: pipe0_q <= merge_bytes(pipe0_q, wbuf_q, byte_cnt_q - 3'h1);
				rcs_pkg::OFS_PIPE1: pipe1_q <= merge_bytes(pipe1_q, wbuf_q, byte_cnt_q - 3'h1);
				rcs_pkg::OFS_PIPE2: pipe2_q <= wdata;
				rcs_pkg::OFS_PIPE3: pipe3_q <= wdata;
				default:            pipe0_q <= pipe0_q;
			endcase
		end
	end

	// Sampled engine state so that status fields have reset values
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			head_pipe_q    <= rcs_pkg::PIPE_NO_EMPTY;
			tx_full_q      <= 1'b0;
			power_detect_q <= 1'b0;
		end else begin
			head_pipe_q    <= i_rx_head_pipe;
			tx_full_q      <= i_tx_fifo_full;
			power_detect_q <= i_power_detect;
		end
	end

	// With acknowledgement on, only the ack marks a packet as sent
	assign tx_sent_set = i_auto_acknowledge ? i_ack_received : i_tx_packet_done;
	assign retry_left  = retry_count_q < i_retry_limit;

	// Event flags; for the receive and sent flags a set in the clearing cycle wins
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_ready_flag_q        <= 1'b0;
			tx_sent_flag_q         <= 1'b0;
			retry_exhausted_flag_q <= 1'b0;
		end else begin
			rx_ready_flag_q <= i_rx_packet_stored
				|| (rx_ready_flag_q && !(wr_status && wdata[rcs_pkg::STS_RX]));
			tx_sent_flag_q <= tx_sent_set
				|| (tx_sent_flag_q && !(wr_status && wdata[rcs_pkg::STS_TX]));
			retry_exhausted_flag_q <= (i_ack_missed && !retry_exhausted_flag_q && !retry_left)
				|| (retry_exhausted_flag_q && !(wr_status && wdata[rcs_pkg::STS_RETRY]));
		end
	end

	// Retry and lost packet counters; events are ignored while blocked
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			retry_count_q        <= 4'h0;
			lost_packet_count_q  <= 4'h0;
			o_retransmit_request <= 1'b0;
		end else begin
			o_retransmit_request <= 1'b0;
			if (!retry_exhausted_flag_q) begin
				if (i_tx_packet_start) begin
					retry_count_q <= 4'h0;
				end else if (i_ack_missed && retry_left) begin
					retry_count_q        <= retry_count_q + 4'h1;
					o_retransmit_request <= 1'b1;
				end
			end
			if (wr_channel) begin
				lost_packet_count_q <= 4'h0;
			end else if (i_ack_missed && !retry_exhausted_flag_q && !retry_left
					&& lost_packet_count_q != rcs_pkg::LOST_MAX) begin
				lost_packet_count_q <= lost_packet_count_q + 4'h1;
			end
		end
	end

	// Interrupt line from flags not masked
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_radio_irq_n <= 1'b1;
		end else begin
			o_radio_irq_n <= !(|({rx_ready_flag_q, tx_sent_flag_q, retry_exhausted_flag_q}
				& ~i_irq_mask));
		end
	end

	// Radio controls straight from the setup and channel registers, link block from the retry flag
	assign o_channel_number      = channel_q[rcs_pkg::CHANNEL_BITS-1:0];
	assign o_carrier_test_enable = setup_q[rcs_pkg::SETUP_CARRIER];
	assign o_force_lock          = setup_q[rcs_pkg::SETUP_LOCK];
	assign o_tx_power_level      = setup_q[rcs_pkg::SETUP_PWR_LSB +: 2];
	assign o_link_blocked        = retry_exhausted_flag_q;

	// Slow bit wins, so the reserved code never leaves the block
	always_comb begin
		if (setup_q[rcs_pkg::SETUP_SLOW]) begin
			o_data_rate = rcs_pkg::RCS_RATE_250K;
		end else if (setup_q[rcs_pkg::SETUP_FAST]) begin
			o_data_rate = rcs_pkg::RCS_RATE_2M;
		end else begin
			o_data_rate = rcs_pkg::RCS_RATE_1M;
		end
	end

	// Width mask; the illegal code is served as five bytes
	always_comb begin
		unique case (i_addr_width_cfg)
			2'h1:    width_mask = 40'h00_00FF_FFFF;
			2'h2:    width_mask = 40'h00_FFFF_FFFF;
			default: width_mask = 40'hFF_FFFF_FFFF;
		endcase
	end

	assign o_pipe0_match_address = pipe0_q & width_mask;
	assign o_pipe1_match_address = pipe1_q & width_mask;
	assign o_pipe2_match_address = {pipe1_q[39:8], pipe2_q} & width_mask;
	assign o_pipe3_match_address = {pipe1_q[39:8], pipe3_q} & width_mask;

	// Checks
	a_retry_step: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		i_ack_missed && !i_tx_packet_start && !o_link_blocked && retry_count_q < i_retry_limit
		|=> retry_count_q == $past(retry_count_q) + 4'h1 && o_retransmit_request)
		else $error("retry not taken while retries remain");

	a_channel_top: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		wr_channel |=> channel_q == {1'b0, $past(wdata[6:0])} && lost_packet_count_q == 4'h0)
		else $error("channel write wrong");

	a_slow_wins: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		setup_q[rcs_pkg::SETUP_SLOW] |-> o_data_rate == rcs_pkg::RCS_RATE_250K)
		else $error("slow rate not selected");

	a_status_out: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		cs_fall |=> tx_shift_q == $past(status_byte))
		else $error("status not loaded for shifting");

	a_rx_flag_set: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		i_rx_packet_stored |=> rx_ready_flag_q ##1 (rx_ready_flag_q || $past(wr_status)))
		else $error("receive flag lost");

	a_block_hold: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		o_link_blocked && !wr_status |=> o_link_blocked && !o_retransmit_request)
		else $error("block released without clear");

	a_lost_sat: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		(lost_packet_count_q == rcs_pkg::LOST_MAX && !wr_channel) [*2] |=> lost_packet_count_q == rcs_pkg::LOST_MAX)
		else $error("lost counter left saturation");

	a_retry_clear: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		i_tx_packet_start && !o_link_blocked |=> retry_count_q == 4'h0)
		else $error("retry count not cleared");

	a_irq_follow: assert property (
		@(posedge i_clock) disable iff (!i_reset_n)
		$rose(tx_sent_flag_q) && !i_irq_mask[1] |=> !o_radio_irq_n)
		else $error("interrupt not raised");
endmodule : rcs_radio_regs

// [tb/rcs_host_model.sv]
// Host controller model issuing serial register frames
`timescale 1ns/1ns
module rcs_host_model (
	// Clock
	input  wire logic i_clock,
	// Serial port to the device
	output logic      o_spi_sck,
	output logic      o_spi_cs_n,
	output logic      o_spi_mosi,
	input  wire logic i_spi_miso,
	input  wire logic i_spi_miso_en
);
	// Idle: deselected, serial clock parked low
	initial begin
		o_spi_sck = 1'b0;
		o_spi_cs_n = 1'b1;
		o_spi_mosi = 1'b0;
	end

	// Command byte then n data bytes; every half bit lasts two clocks, twice the one clock the port needs
	task automatic frame(input logic [7:0] cmd, input int n, input logic [39:0] wd,
			output logic [7:0] sts, output logic [39:0] rd);
		logic [7:0] tx;
		logic [7:0] rx;
		rd = '0;
		sts = '0;
		@(negedge i_clock);
		o_spi_cs_n = 1'b0;
		for (int k = 0; k <= n; k++) begin
			tx = (k == 0) ? cmd : wd[7:0];
			if (k > 0)
				wd = wd >> 8;
			for (int j = 7; j >= 0; j--) begin
				o_spi_mosi = tx[j];
				repeat (2) @(negedge i_clock);
				// Unknown when the device is not driving, so a stale level never matches
				rx[j] = i_spi_miso_en ? i_spi_miso : 1'bx;
				o_spi_sck = 1'b1;
				repeat (2) @(negedge i_clock);
				o_spi_sck = 1'b0;
			end
			if (k == 0)
				sts = rx;
			else
				rd[8*k-8 +: 8] = rx;
		end
		// Deselect, flip the released data line, keep the gap between frames
		@(negedge i_clock);
		o_spi_cs_n = 1'b1;
		o_spi_mosi = ~o_spi_mosi;
		repeat (3) @(negedge i_clock);
	endtask : frame
endmodule : rcs_host_model

// [tb/rcs_radio_regs_tb.sv]
// Self-checking bench for the radio register block
`timescale 1ns/1ns
module rcs_radio_regs_tb;
	logic i_clock = 1'b0, i_reset_n = 1'b0, i_spi_sck, i_spi_cs_n, i_spi_mosi, o_spi_miso, o_spi_miso_en;
	logic [1:0] i_addr_width_cfg = 2'h3;
	logic [3:0] i_retry_limit = 4'h0;
	logic [2:0] i_irq_mask = 3'h0, i_rx_head_pipe = 3'h7;
	logic i_auto_acknowledge = 0, i_rx_packet_stored = 0, i_tx_fifo_full = 0, i_tx_packet_start = 0;
	logic i_tx_packet_done = 0, i_ack_received = 0, i_ack_missed = 0, i_power_detect = 0;
	logic [6:0] o_channel_number;
	logic o_carrier_test_enable, o_force_lock, o_retransmit_request, o_link_blocked, o_radio_irq_n;
	rcs_pkg::rcs_rate_e o_data_rate;
	logic [1:0] o_tx_power_level;
	logic [39:0] o_pipe0_match_address, o_pipe1_match_address, o_pipe2_match_address, o_pipe3_match_address;
	int mismatches = 0, checks = 0, cycles = 0, rr_n = 0, n0;
	logic [31:0] seed = 32'h07b4_4925;
	logic [7:0] st, v;
	logic [39:0] rd, m, d0, d1, p0e, p1e;
	logic [3:0] lost, lims [3];
	logic [39:0] rst_tab [9] = '{40'h02, 40'h0E, 40'h0E, 40'h00, 40'h00, 40'hE7_E7E7_E7E7,
		40'hC2_C2C2_C2C2, 40'hC3, 40'hC4};

	rcs_radio_regs DUT (.i_clock, .i_reset_n, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi, .o_spi_miso,
		.o_spi_miso_en, .i_addr_width_cfg, .i_retry_limit, .i_auto_acknowledge, .i_irq_mask,
		.i_rx_packet_stored, .i_rx_head_pipe, .i_tx_fifo_full, .i_tx_packet_start, .i_tx_packet_done,
		.i_ack_received, .i_ack_missed, .i_power_detect, .o_channel_number, .o_carrier_test_enable,
		.o_data_rate, .o_force_lock, .o_tx_power_level, .o_retransmit_request, .o_link_blocked,
		.o_radio_irq_n, .o_pipe0_match_address, .o_pipe1_match_address, .o_pipe2_match_address,
		.o_pipe3_match_address);
	rcs_host_model host (.i_clock, .o_spi_sck(i_spi_sck), .o_spi_cs_n(i_spi_cs_n),
		.o_spi_mosi(i_spi_mosi), .i_spi_miso(o_spi_miso), .i_spi_miso_en(o_spi_miso_en));

	// 25 MHz clock
	always #20 i_clock = ~i_clock;

	// Retransmit pulses counted as they come, since their exact cycle is the design's choice
	always @(posedge i_clock) begin
		cycles++;
		if (o_retransmit_request === 1'b1)
			rr_n++;
		if (cycles == 30000) begin
			mismatches++;
			conclude();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic rcs_pkg::rcs_rate_e rate_of(input logic [7:0] s);
		if (s[5])
			return rcs_pkg::RCS_RATE_250K;
		return s[3] ? rcs_pkg::RCS_RATE_2M : rcs_pkg::RCS_RATE_1M;
	endfunction : rate_of

	// Low bytes in use for an address width code; 00 counts as five
	function automatic logic [39:0] wmask(input logic [1:0] w);
		return (w == 2'h1) ? 40'h00_00FF_FFFF : (w == 2'h2) ? 40'h00_FFFF_FFFF : 40'hFF_FFFF_FFFF;
	endfunction : wmask

	task automatic cmp(input string name, input logic [39:0] exp, input logic [39:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	task automatic wr(input logic [4:0] a, input int n, input logic [39:0] d);
		host.frame({rcs_pkg::CMD_WRITE, a}, n, d, st, rd);
	endtask : wr

	task automatic rdr(input logic [4:0] a, input int n);
		host.frame({rcs_pkg::CMD_READ, a}, n, 40'h0, st, rd);
	endtask : rdr

	task automatic pulse(ref logic s);
		@(negedge i_clock);
		s = 1'b1;
		@(negedge i_clock);
		s = 1'b0;
		repeat (2) @(negedge i_clock);
	endtask : pulse

	// Event sets a flag and pulls the line low unless masked; writing one clears it
	task automatic flag(ref logic s, input logic a, input logic [7:0] e);
		i_auto_acknowledge = a;
		pulse(s);
		rdr(rcs_pkg::OFS_STATUS, 1);
		cmp("event flags", e, st & 8'h70);
		cmp("irq line", (e == 8'h00), o_radio_irq_n);
		i_irq_mask = 3'h7;
		repeat (2) @(negedge i_clock);
		cmp("masked irq", 1'b1, o_radio_irq_n);
		i_irq_mask = 3'h0;
		wr(rcs_pkg::OFS_STATUS, 1, 40'h70);
		cmp("cleared", e | 8'h0E, st & 8'h7E);
		rdr(rcs_pkg::OFS_STATUS, 1);
		cmp("after clear", 8'h0E, rd);
	endtask : flag

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		repeat (3) @(negedge i_clock);
		i_reset_n = 1'b1;
		for (int a = 0; a < 9; a++) begin
			rdr(5'(a + 5), (a == 5 || a == 6) ? 5 : 1);
			cmp("reset value", rst_tab[a], rd);
			cmp("status shift", 8'h0E, st);
		end
		cmp("reset controls", {rcs_pkg::RCS_RATE_2M, 2'b11}, {o_data_rate, o_tx_power_level});
		$display("test reset done");
		for (int k = 0; k < 10; k++) begin
			v = (k < 4) ? {2'b00, k[1], 1'b0, k[0], 3'b111} : rnd();
			wr(rcs_pkg::OFS_SETUP, 1, v);
			rdr(rcs_pkg::OFS_SETUP, 1);
			cmp("setup", v & rcs_pkg::SETUP_WMASK, rd);
			cmp("rate", rate_of(v), o_data_rate);
			cmp("setup pins", {v[7], v[4], v[2:1]},
				{o_carrier_test_enable, o_force_lock, o_tx_power_level});
		end
		$display("test setup done");
		lims = '{4'h1, 4'(rnd() % 14 + 2), 4'hF};
		lost = 4'h0;
		foreach (lims[q]) begin
			i_retry_limit = lims[q];
			pulse(i_tx_packet_start);
			n0 = rr_n;
			repeat (lims[q]) pulse(i_ack_missed);
			pulse(i_ack_missed);
			lost++;
			cmp("retransmits", 40'(lims[q]), 40'(rr_n - n0));
			rdr(rcs_pkg::OFS_OBSERVE, 1);
			cmp("observe", {lost, lims[q]}, rd);
			cmp("exhausted", 8'h1E, st);
			cmp("blocked irq", 2'b10, {o_link_blocked, o_radio_irq_n});
			pulse(i_tx_packet_start);
			pulse(i_ack_missed);
			rdr(rcs_pkg::OFS_OBSERVE, 1);
			cmp("ignored while blocked", {lost, lims[q], 32'(n0 + lims[q])}, {rd[7:0], 32'(rr_n)});
			wr(rcs_pkg::OFS_STATUS, 1, 40'h10);
			cmp("unblocked", 2'b01, {o_link_blocked, o_radio_irq_n});
			pulse(i_tx_packet_start);
			rdr(rcs_pkg::OFS_OBSERVE, 1);
			cmp("new packet", {lost, 4'h0}, rd);
		end
		// Limit zero exhausts on the first miss; masked so the line stays high
		i_retry_limit = 4'h0;
		i_irq_mask = 3'h1;
		repeat (14) begin
			pulse(i_ack_missed);
			cmp("masked exhaust", 2'b11, {o_link_blocked, o_radio_irq_n});
			wr(rcs_pkg::OFS_STATUS, 1, 40'h10);
		end
		i_irq_mask = 3'h0;
		rdr(rcs_pkg::OFS_OBSERVE, 1);
		cmp("lost saturates", 8'hF0, rd);
		v = rnd() & 8'h7F;
		wr(rcs_pkg::OFS_CHANNEL, 1, v);
		wr(rcs_pkg::OFS_OBSERVE, 1, 40'hFF);
		rdr(rcs_pkg::OFS_OBSERVE, 1);
		cmp("lost cleared", 8'h00, rd);
		rdr(rcs_pkg::OFS_CHANNEL, 1);
		cmp("channel", {v, v[6:0]}, {rd[7:0], o_channel_number});
		rdr(5'h1E, 1);
		cmp("unmapped", 8'h00, rd);
		$display("test retry done");
		flag(i_rx_packet_stored, 1'b0, 8'h40);
		flag(i_tx_packet_done, 1'b0, 8'h20);
		flag(i_tx_packet_done, 1'b1, 8'h00);
		flag(i_ack_received, 1'b1, 8'h20);
		$display("test flags done");
		p0e = 40'hE7_E7E7_E7E7;
		p1e = 40'hC2_C2C2_C2C2;
		for (int k = 1; k < 4; k++) begin
			i_addr_width_cfg = 2'(k);
			m = wmask(i_addr_width_cfg);
			d0 = {rnd(), rnd()};
			d1 = {rnd(), rnd()};
			v = rnd();
			wr(rcs_pkg::OFS_PIPE0, k + 2, d0);
			wr(rcs_pkg::OFS_PIPE1, k + 2, d1);
			wr(rcs_pkg::OFS_PIPE2, 1, v);
			p0e = (p0e & ~m) | (d0 & m);
			p1e = (p1e & ~m) | (d1 & m);
			rdr(rcs_pkg::OFS_PIPE0, 5);
			cmp("pipe0", p0e, rd);
			rdr(rcs_pkg::OFS_PIPE1, 5);
			cmp("pipe1", p1e, rd);
			cmp("pipe0 match", p0e & m, o_pipe0_match_address);
			cmp("pipe1 match", p1e & m, o_pipe1_match_address);
			cmp("pipe2 match", {p1e[39:8], v} & m, o_pipe2_match_address);
			cmp("pipe3 match", {p1e[39:8], 8'hC4} & m, o_pipe3_match_address);
		end
		$display("test pipes done");
		wr(rcs_pkg::OFS_STATUS, 1, 40'h0F);
		for (int k = 0; k < 8; k++) begin
			v = rnd();
			i_rx_head_pipe = (k == 0) ? 3'h6 : v[2:0];
			i_tx_fifo_full = v[3];
			i_power_detect = v[4];
			rdr(rcs_pkg::OFS_STATUS, 1);
			cmp("status fields", {4'h0, i_rx_head_pipe, v[3]}, rd);
			rdr(rcs_pkg::OFS_POWERDET, 1);
			cmp("power detect", {7'h00, v[4]}, rd);
		end
		$display("test status done");
		conclude();
	end
endmodule : rcs_radio_regs_tb
